// File: logic/measurement_readback_regs.sv
// read-only measurement readback registers behind the serial control port
// assumes the serial port engine supplies address, an addressed level and a
// one-cycle read strobe on clk; measurement engines deliver codes on clk
`timescale 1ns/1ps
`include "readback_params.svh"

module measurement_readback_regs (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [7:0]  reg_addr,
  input  wire logic        reg_addressed,
  input  wire logic        reg_rd,
  output logic      [7:0]  rd_data,
  output logic             rd_hit,
  input  wire logic        aux_supply_present_mode,
  input  wire logic [11:0] battery_supply_code,
  input  wire logic [11:0] aux_supply_code,
  input  wire logic        supply_sample_valid,
  input  wire logic        supply_max_clear,
  input  wire logic [11:0] temperature_code,
  input  wire logic        temperature_valid,
  input  wire logic        rail_a_switch_control,
  input  wire logic        rail_a_output_low,
  output logic      [10:0] supply_scale_uv,
  output logic             switch_output_still_low
);

  // ------------------------------------------------------------------
  // reset release
  // ------------------------------------------------------------------
  logic rst_meta_ff;
  logic rst_sync_n;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_ff <= 1'b0;
      rst_sync_n  <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_n  <= rst_meta_ff;
    end
  end

  // ------------------------------------------------------------------
  // pin input
  // ------------------------------------------------------------------
  logic output_low_clean;

  input_sync #(
    .WIDTH (1)
  ) u_low_sync (
    .clk   (clk),
    .rst_n (rst_sync_n),
    .din   (rail_a_output_low),
    .dout  (output_low_clean)
  );

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  rd_data;
    logic        rd_hit;
    logic [11:0] max_live;
    logic [11:0] max_pub;
    logic [11:0] temp_live;
    logic [11:0] temp_pub;
    logic [7:0]  max_shadow;
    logic [7:0]  temp_shadow;
    logic        max_shadow_valid;
    logic        temp_shadow_valid;
    logic        stat_pub;
    logic [10:0] scale;
  } bank_state_type;

  bank_state_type state_ff;
  bank_state_type nxt_state;

  readback_pkg::reg_sel_type sel;
  logic                      frozen;
  logic [11:0]               new_supply;

  // ------------------------------------------------------------------
  // decode
  // ------------------------------------------------------------------
  always_comb begin
    unique case (reg_addr)
      `ADDR_SUPPLY_MAX_HIGH_NIBBLE:  sel = readback_pkg::SEL_MAX_HIGH;
      `ADDR_SUPPLY_MAX_LOW_BYTE:     sel = readback_pkg::SEL_MAX_LOW;
      `ADDR_TEMPERATURE_HIGH_NIBBLE: sel = readback_pkg::SEL_TEMP_HIGH;
      `ADDR_TEMPERATURE_LOW_BYTE:    sel = readback_pkg::SEL_TEMP_LOW;
      `ADDR_SWITCHED_OUTPUT_STATUS:  sel = readback_pkg::SEL_SW_STATUS;
      default:                       sel = readback_pkg::SEL_NONE;
    endcase
  end

  // freeze only while one of our registers is addressed
  assign frozen = reg_addressed && (sel != readback_pkg::SEL_NONE);

  // source chosen by the supply-present mode
  assign new_supply = aux_supply_present_mode ? aux_supply_code : battery_supply_code;

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;

    // trackers keep running underneath; only the published copies freeze
    if (supply_sample_valid && (supply_max_clear || new_supply > state_ff.max_live)) begin
      nxt_state.max_live = new_supply;
      nxt_state.scale = aux_supply_present_mode ? `AUX_UV_PER_COUNT : `BATT_UV_PER_COUNT;
    end else if (supply_max_clear) begin
      nxt_state.max_live = `RESET_CODE;
    end
    // code kept whole so the sign nibble stays two's complement
    if (temperature_valid) begin
      nxt_state.temp_live = temperature_code;
    end

    if (!frozen) begin
      nxt_state.max_pub  = state_ff.max_live;
      nxt_state.temp_pub = state_ff.temp_live;
      nxt_state.stat_pub = rail_a_switch_control && output_low_clean;
    end

    if (reg_rd) begin
      nxt_state.rd_hit = (sel != readback_pkg::SEL_NONE);
      unique case (sel)
        readback_pkg::SEL_MAX_HIGH: begin
          nxt_state.rd_data = {`RSVD_NIBBLE,
                               state_ff.max_pub[`HIGH_NIBBLE_MSB:`HIGH_NIBBLE_LSB]};
          nxt_state.max_shadow       = state_ff.max_pub[`LOW_BYTE_MSB:`LOW_BYTE_LSB];
          nxt_state.max_shadow_valid = 1'b1;
        end
        readback_pkg::SEL_MAX_LOW: begin
          nxt_state.rd_data = state_ff.max_shadow_valid ? state_ff.max_shadow
                              : state_ff.max_pub[`LOW_BYTE_MSB:`LOW_BYTE_LSB];
          nxt_state.max_shadow_valid = 1'b0;
        end
        readback_pkg::SEL_TEMP_HIGH: begin
          nxt_state.rd_data = {`RSVD_NIBBLE,
                               state_ff.temp_pub[`HIGH_NIBBLE_MSB:`HIGH_NIBBLE_LSB]};
          nxt_state.temp_shadow       = state_ff.temp_pub[`LOW_BYTE_MSB:`LOW_BYTE_LSB];
          nxt_state.temp_shadow_valid = 1'b1;
        end
        readback_pkg::SEL_TEMP_LOW: begin
          nxt_state.rd_data = state_ff.temp_shadow_valid ? state_ff.temp_shadow
                              : state_ff.temp_pub[`LOW_BYTE_MSB:`LOW_BYTE_LSB];
          nxt_state.temp_shadow_valid = 1'b0;
        end
        readback_pkg::SEL_SW_STATUS: begin
          nxt_state.rd_data = {`RSVD_STATUS, state_ff.stat_pub};
        end
        readback_pkg::SEL_NONE: begin
          nxt_state.rd_data = `UNMAPPED_READ;
        end
      endcase
    end
  end

  // ------------------------------------------------------------------
  // registers
  // ------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign rd_data                 = state_ff.rd_data;
  assign rd_hit                  = state_ff.rd_hit;
  assign supply_scale_uv         = state_ff.scale;
  assign switch_output_still_low = state_ff.stat_pub;

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_sync_n);

  sequence s_read_max_high;
    reg_rd && (reg_addr == `ADDR_SUPPLY_MAX_HIGH_NIBBLE);
  endsequence

  sequence s_read_max_low;
    reg_rd && (reg_addr == `ADDR_SUPPLY_MAX_LOW_BYTE);
  endsequence

  sequence s_read_temp_high;
    reg_rd && (reg_addr == `ADDR_TEMPERATURE_HIGH_NIBBLE);
  endsequence

  sequence s_read_temp_low;
    reg_rd && (reg_addr == `ADDR_TEMPERATURE_LOW_BYTE);
  endsequence

  property p_max_low_read;
    s_read_max_low and (!state_ff.max_shadow_valid) |=>
      rd_data == $past(state_ff.max_pub[`LOW_BYTE_MSB:`LOW_BYTE_LSB]);
  endproperty
  a_max_low_read: assert property (p_max_low_read)
    else $error("supply max low byte read wrong");

  property p_max_high_read;
    s_read_max_high |=> rd_data == {`RSVD_NIBBLE,
      $past(state_ff.max_pub[`HIGH_NIBBLE_MSB:`HIGH_NIBBLE_LSB])};
  endproperty
  a_max_high_read: assert property (p_max_high_read)
    else $error("supply max high nibble read wrong");

  property p_aux_select;
    supply_sample_valid && aux_supply_present_mode && supply_max_clear |=>
      state_ff.max_live == $past(aux_supply_code) && supply_scale_uv == `AUX_UV_PER_COUNT;
  endproperty
  a_aux_select: assert property (p_aux_select)
    else $error("aux supply not selected");

  property p_batt_select;
    supply_sample_valid && !aux_supply_present_mode && supply_max_clear |=>
      state_ff.max_live == $past(battery_supply_code) && supply_scale_uv == `BATT_UV_PER_COUNT;
  endproperty
  a_batt_select: assert property (p_batt_select)
    else $error("battery supply not selected");

  property p_freeze;
    frozen |=> $stable(state_ff.max_pub) && $stable(state_ff.temp_pub)
               && $stable(switch_output_still_low);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("published value moved while addressed");

  property p_shadow_pair;
    s_read_max_high ##1 (!reg_rd)[*1] ##1 s_read_max_low |=>
      rd_data == $past(state_ff.max_pub[`LOW_BYTE_MSB:`LOW_BYTE_LSB], 3);
  endproperty
  a_shadow_pair: assert property (p_shadow_pair)
    else $error("low byte did not come from shadow");

  property p_temp_high;
    reg_rd && (reg_addr == `ADDR_TEMPERATURE_HIGH_NIBBLE) |=>
      rd_data == {`RSVD_NIBBLE, $past(state_ff.temp_pub[`HIGH_NIBBLE_MSB:`HIGH_NIBBLE_LSB])};
  endproperty
  a_temp_high: assert property (p_temp_high)
    else $error("temperature high nibble read wrong");

  property p_temp_low;
    reg_rd && (reg_addr == `ADDR_TEMPERATURE_LOW_BYTE) && !state_ff.temp_shadow_valid |=>
      rd_data == $past(state_ff.temp_pub[`LOW_BYTE_MSB:`LOW_BYTE_LSB]);
  endproperty
  a_temp_low: assert property (p_temp_low)
    else $error("temperature low byte read wrong");

  property p_status;
    !frozen |=> switch_output_still_low == $past(rail_a_switch_control && output_low_clean);
  endproperty
  a_status: assert property (p_status)
    else $error("switch status does not follow rail state");

  property p_resume;
    !frozen ##1 !frozen |=> state_ff.max_pub == $past(state_ff.max_live)
                            && state_ff.temp_pub == $past(state_ff.temp_live);
  endproperty
  a_resume: assert property (p_resume)
    else $error("published value not tracking after access");

  // the temperature pair must come from the shadow even if a new code lands in between
  property p_temp_shadow_pair;
    s_read_temp_high ##1 (!reg_rd)[*1] ##1 s_read_temp_low |=>
      rd_data == $past(state_ff.temp_pub[`LOW_BYTE_MSB:`LOW_BYTE_LSB], 3);
  endproperty
  a_temp_shadow_pair: assert property (p_temp_shadow_pair)
    else $error("temperature low byte did not come from shadow");

  property p_aux_scale;
    supply_sample_valid && aux_supply_present_mode && (new_supply > state_ff.max_live) |=>
      supply_scale_uv == `AUX_UV_PER_COUNT;
  endproperty
  a_aux_scale: assert property (p_aux_scale)
    else $error("aux scale not reported for new maximum");

  property p_status_read;
    reg_rd && (reg_addr == `ADDR_SWITCHED_OUTPUT_STATUS) |=>
      rd_data == {`RSVD_STATUS, $past(state_ff.stat_pub)};
  endproperty
  a_status_read: assert property (p_status_read)
    else $error("switch status read wrong");

endmodule

// File: logic/readback_params.svh
// named constants for the measurement readback register bank
// assumes inclusion by the bank and both sim files; definitions only
`ifndef READBACK_PARAMS_SVH
`define READBACK_PARAMS_SVH

// ------------------------------------------------------------------
// register offsets on the serial control port
// ------------------------------------------------------------------
`define ADDR_SUPPLY_MAX_HIGH_NIBBLE  8'h1f
`define ADDR_SUPPLY_MAX_LOW_BYTE     8'h20
`define ADDR_TEMPERATURE_HIGH_NIBBLE 8'h21
`define ADDR_TEMPERATURE_LOW_BYTE    8'h22
`define ADDR_SWITCHED_OUTPUT_STATUS  8'h23

// ------------------------------------------------------------------
// reset values and field layout
// ------------------------------------------------------------------
`define RESET_BYTE        8'h00
`define RESET_CODE        12'h000
`define UNMAPPED_READ     8'h00
`define RSVD_NIBBLE       4'h0
`define RSVD_STATUS       7'h00
`define HIGH_NIBBLE_MSB   11
`define HIGH_NIBBLE_LSB   8
`define LOW_BYTE_MSB      7
`define LOW_BYTE_LSB      0
`define STATUS_LOW_BIT    0

// ------------------------------------------------------------------
// code scaling, for software and for the scale output
// ------------------------------------------------------------------
`define BATT_UV_PER_COUNT 11'h5d2
`define AUX_UV_PER_COUNT  11'h3f2
`define RESET_SCALE       11'h000
`define TEMP_OFFSET_C     8'h28
`define TEMP_CODE_BIAS    12'h002
`define TEMP_COUNTS_PER_C 6.04236

`endif

// File: logic/readback_pkg.sv
// types shared by the measurement readback register bank
// assumes nothing of its surroundings
package readback_pkg;

  // ------------------------------------------------------------------
  // register decode
  // ------------------------------------------------------------------
  typedef enum logic [2:0] {
    SEL_NONE,
    SEL_MAX_HIGH,
    SEL_MAX_LOW,
    SEL_TEMP_HIGH,
    SEL_TEMP_LOW,
    SEL_SW_STATUS
  } reg_sel_type;

endpackage

// File: logic/input_sync.sv
// three-stage synchroniser for pin inputs
// assumes the inputs are asynchronous to clk; reset is already synchronised
`timescale 1ns/1ps

module input_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] held;
  } sync_state_type;

  sync_state_type state_ff;
  sync_state_type nxt_state;

  // s1 feeds s2 only; a change counts once s2 and s3 agree
  always_comb begin
    nxt_state    = state_ff;
    nxt_state.s1 = din;
    nxt_state.s2 = state_ff.s1;
    nxt_state.s3 = state_ff.s2;
    for (int i = 0; i < WIDTH; i++) begin
      if (state_ff.s2[i] == state_ff.s3[i]) begin
        nxt_state.held[i] = state_ff.s3[i];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign dout = state_ff.held;

endmodule

// File: sim/host_model.sv
// host side of the serial control port: register reads only
// assumes the bank takes reg_rd on the rising edge of clk
`timescale 1ns/1ps
`include "readback_params.svh"

module host_model (
  input  wire logic       clk,
  input  wire logic [7:0] rd_data,
  input  wire logic       rd_hit,
  output logic      [7:0] reg_addr,
  output logic            reg_addressed,
  output logic            reg_rd
);
  // ------------------------------------------------------------------
  // bus tasks
  // ------------------------------------------------------------------
  // no write path exists, so reserved bits are never set
  initial begin
    reg_addr      = 8'h00;
    reg_addressed = 1'b0;
    reg_rd        = 1'b0;
  end

  // selection is kept after the read so a low byte can follow at once
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic h);
    @(negedge clk);
    reg_addressed = 1'b1;
    reg_addr      = a;
    reg_rd        = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    d      = rd_data;
    h      = rd_hit;
  endtask

  // released address shows the inverse so a stale decode cannot pass
  task automatic release_bus();
    @(negedge clk);
    reg_addressed = 1'b0;
    reg_addr      = ~reg_addr;
  endtask

  // high part first, low byte right after, under one selection
  task automatic rd_pair(input logic [7:0] hi_a, output logic [15:0] v);
    logic [7:0] hi;
    logic [7:0] lo;
    logic       h;
    rd(hi_a, hi, h);
    rd(hi_a + 8'h01, lo, h);
    release_bus();
    v = {hi, lo};
  endtask

  // poll the still-low flag until it clears, bounded
  task automatic poll_switch(output logic [7:0] d);
    logic h;
    for (int i = 0; i < 16; i++) begin
      rd(`ADDR_SWITCHED_OUTPUT_STATUS, d, h);
      release_bus();
      if (d[0] === 1'b0) break;
    end
  endtask
endmodule

// File: sim/tb_measurement_readback_regs.sv
// self-checking bench for the measurement readback register bank
// assumes host_model drives the read port; the bench drives the measurements
`timescale 1ns/1ps
`include "readback_params.svh"

module tb_measurement_readback_regs;
  logic        clk, rst_n, reg_addressed, reg_rd, rd_hit, mode, s_valid, s_clr;
  logic        t_valid, sw_ctrl, out_low, still_low, h;
  logic [7:0]  reg_addr, rd_data, d;
  logic [11:0] batt, aux, t_code;
  logic [10:0] scale;
  logic [15:0] v;
  int          miscompares, n_tests, cycles;

  host_model host (.clk(clk), .rd_data(rd_data), .rd_hit(rd_hit), .reg_addr(reg_addr),
    .reg_addressed(reg_addressed), .reg_rd(reg_rd));

  measurement_readback_regs dut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_addressed(reg_addressed), .reg_rd(reg_rd), .rd_data(rd_data), .rd_hit(rd_hit),
    .aux_supply_present_mode(mode), .battery_supply_code(batt), .aux_supply_code(aux),
    .supply_sample_valid(s_valid), .supply_max_clear(s_clr), .temperature_code(t_code),
    .temperature_valid(t_valid), .rail_a_switch_control(sw_ctrl),
    .rail_a_output_low(out_low), .supply_scale_uv(scale),
    .switch_output_still_low(still_low));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic rd_check(input logic [7:0] a, input logic [7:0] exp, input logic hit);
    host.rd(a, d, h);
    host.release_bus();
    check({h, d}, {hit, exp});
  endtask

  task automatic sample(input logic m, input logic [11:0] b, input logic [11:0] x, input logic c);
    @(negedge clk);
    {mode, batt, aux, s_valid, s_clr} = {m, b, x, 1'b1, c};
    @(negedge clk);
    {s_valid, s_clr} = 2'b00;
    repeat (3) @(negedge clk);
  endtask

  task automatic temp(input logic [11:0] c);
    @(negedge clk);
    {t_code, t_valid} = {c, 1'b1};
    @(negedge clk);
    t_valid = 1'b0;
    repeat (3) @(negedge clk);
  endtask

  // a hang costs a mismatch and ends the run here
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      final_report();
    end
  end

  // ------------------------------------------------------------------
  // sequence
  // ------------------------------------------------------------------
  initial begin
    {rst_n, mode, s_valid, s_clr, t_valid, sw_ctrl, out_low} = 7'h00;
    {batt, aux, t_code} = 36'h0;
    {miscompares, n_tests, cycles} = {32'd0, 32'd0, 32'd0};
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    for (logic [7:0] a = 8'h1f; a <= 8'h23; a++) begin
      rd_check(a, `RESET_BYTE, 1'b1);
    end
    rd_check(8'h24, `UNMAPPED_READ, 1'b0);
    rd_check(8'h1e, `UNMAPPED_READ, 1'b0);
    check(scale, `RESET_SCALE);
    // a lower battery sample must not replace the max; aux code is a decoy
    sample(1'b0, 12'h5a3, 12'h7ee, 1'b1);
    sample(1'b0, 12'h100, 12'hfff, 1'b0);
    host.rd_pair(`ADDR_SUPPLY_MAX_HIGH_NIBBLE, v);
    check(v, 16'h05a3);
    check(scale, `BATT_UV_PER_COUNT);
    sample(1'b1, 12'hfff, 12'h7ff, 1'b0);
    host.rd_pair(`ADDR_SUPPLY_MAX_HIGH_NIBBLE, v);
    check(v, 16'h07ff);
    check(scale, `AUX_UV_PER_COUNT);
    sample(1'b1, 12'h000, 12'h050, 1'b1);
    host.rd_pair(`ADDR_SUPPLY_MAX_HIGH_NIBBLE, v);
    check(v, 16'h0050);
    temp(12'hf9c);
    host.rd_pair(`ADDR_TEMPERATURE_HIGH_NIBBLE, v);
    check(v, 16'h0f9c);
    temp(12'h123);
    host.rd_pair(`ADDR_TEMPERATURE_HIGH_NIBBLE, v);
    check(v, 16'h0123);
    // shadow survives a new sample, then is used once
    host.rd(`ADDR_TEMPERATURE_HIGH_NIBBLE, d, h);
    host.release_bus();
    temp(12'h1ab);
    rd_check(`ADDR_TEMPERATURE_LOW_BYTE, 8'h23, 1'b1);
    rd_check(`ADDR_TEMPERATURE_LOW_BYTE, 8'hab, 1'b1);
    // new max arrives while the low byte stays selected
    host.rd(`ADDR_SUPPLY_MAX_LOW_BYTE, d, h);
    sample(1'b1, 12'h000, 12'h0c4, 1'b0);
    host.rd(`ADDR_SUPPLY_MAX_LOW_BYTE, d, h);
    check(d, 8'h50);
    host.release_bus();
    repeat (3) @(negedge clk);
    rd_check(`ADDR_SUPPLY_MAX_LOW_BYTE, 8'hc4, 1'b1);
    {sw_ctrl, out_low} = 2'b11;
    repeat (8) @(negedge clk);
    rd_check(`ADDR_SWITCHED_OUTPUT_STATUS, 8'h01, 1'b1);
    check(still_low, 1'b1);
    out_low = 1'b0;
    host.poll_switch(d);
    check(d, 8'h00);
    @(negedge clk);
    {sw_ctrl, out_low} = 2'b01;
    repeat (8) @(negedge clk);
    rd_check(`ADDR_SWITCHED_OUTPUT_STATUS, 8'h00, 1'b1);
    check(still_low, 1'b0);
    final_report();
  end
endmodule
